// [verilog/asc_dev.sv]
/*
  Analog spindle speed device end: Avalon-MM register slave, gear handling,
  two spindle slices with 12-bit codes to PLC and converter.
  Assumes one mclk domain, the PLC end on the asc_if plc modport.
*/
`timescale 1ns/100ps
`default_nettype none
`include "asc_params.svh"
module asc_dev #(
  parameter int SPD_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  asc_if.dev link,
  output asc_pkg::asc_code_t converterCodeFirst,
  output asc_pkg::asc_code_t converterCodeSecond
);
  if (SPD_W < 2 || SPD_W > 16) $error("asc_dev: SPD_W out of range");
  if (`ASC_GEARS != 4) $error("asc_dev: gear decode assumes four gears");
  // ****************************************
  // bus slave
  // ****************************************
  logic ackQ;
  logic [31:0] rdataQ;
  logic [`ASC_CTRL_W-1:0] ctrlQ;
  logic [SPD_W-1:0] speedCmdQ;
  logic signed [15:0] gainQ;
  logic signed [15:0] offsetQ;
  logic [SPD_W-1:0] maxQ [2][`ASC_GEARS];
  logic [SPD_W-1:0] spdQ [2];
  asc_pkg::asc_gear_t gearQ [2];
  asc_pkg::asc_code_t rawCode [2];
  asc_pkg::asc_code_t finalCode [2];
  asc_pkg::asc_code_t codeOutQ [2];
  asc_pkg::asc_code_t convQ [2];
  asc_pkg::asc_gear_t autoGear;
  logic strobeQ;

  wire logic req = read | write;
  wire logic wrTake = write & ackQ;
  assign waitrequest = req & ~ackQ;
  assign readdata = rdataQ;
  wire logic cmdWrite = wrTake && address == `ASC_REG_SPEED;
  // gear maxima sit in two aligned groups of four words
  wire logic maxFirstHit = address[3:2] == 2'(`ASC_REG_MAX1 >> 2);
  wire logic maxSecondHit = address[3:2] == 2'(`ASC_REG_MAX2 >> 2);

  wire asc_pkg::asc_scheme_t scheme = asc_pkg::asc_scheme_t'(ctrlQ[`ASC_CTRL_SCHEME]);
  wire logic autoMode = scheme == asc_pkg::ASC_AUTO_GEAR;
  wire logic dualMode = ~autoMode & ctrlQ[`ASC_CTRL_DUAL];
  wire logic tapping = ctrlQ[`ASC_CTRL_TAP];
  wire logic [15:0] gearStat = {12'h000, gearQ[1], gearQ[0]};

  // unmapped words read as zero
  wire logic [31:0] rdMux =
    (address == `ASC_REG_CTRL) ? 32'(ctrlQ) :
    (address == `ASC_REG_SPEED) ? 32'(speedCmdQ) :
    (address == `ASC_REG_GAIN) ? {16'h0000, gainQ} :
    (address == `ASC_REG_OFFSET) ? {16'h0000, offsetQ} :
    maxFirstHit ? 32'(maxQ[0][address[1:0]]) :
    maxSecondHit ? 32'(maxQ[1][address[1:0]]) :
    (address == `ASC_REG_CODES) ? {8'h00, codeOutQ[1], codeOutQ[0]} :
    (address == `ASC_REG_GEARS) ? {16'h0000, gearStat} : 32'h0;

  // one wait state on every access
  always_ff @(posedge mclk) begin
    if (rst) begin
      ackQ <= 1'b0;
      rdataQ <= 32'h0;
    end else begin
      ackQ <= req & ~ackQ;
      rdataQ <= (read & ~ackQ) ? rdMux : rdataQ;
    end
  end

  // configuration writes; maxima of unused gears are zero by software
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrlQ <= `ASC_CTRL_RST;
      speedCmdQ <= '0;
      gainQ <= 16'h0000;
      offsetQ <= 16'h0000;
      for (int s = 0; s < 2; s++) begin
        for (int g = 0; g < `ASC_GEARS; g++) begin
          maxQ[s][g] <= '0;
        end
      end
    end else if (wrTake) begin
      if (address == `ASC_REG_CTRL) ctrlQ <= writedata[`ASC_CTRL_W-1:0];
      if (address == `ASC_REG_SPEED) speedCmdQ <= writedata[SPD_W-1:0];
      if (address == `ASC_REG_GAIN) gainQ <= writedata[15:0];
      if (address == `ASC_REG_OFFSET) offsetQ <= writedata[15:0];
      if (maxFirstHit) maxQ[0][address[1:0]] <= writedata[SPD_W-1:0];
      if (maxSecondHit) maxQ[1][address[1:0]] <= writedata[SPD_W-1:0];
    end
  end

  // ****************************************
  // automatic gear choice for the first spindle
  // ****************************************
  wire logic [3:0] fits;
  for (genvar g = 0; g < `ASC_GEARS; g++) begin : gFit
    assign fits[g] = maxQ[0][g] != '0 && spdQ[0] <= maxQ[0][g];
  end
  // lowest gear whose range holds the speed, else top gear
  assign autoGear = fits[0] ? 2'd0 : fits[1] ? 2'd1 : fits[2] ? 2'd2 : 2'd3;
  wire logic [3:0] gearOneHot = 4'h1 << gearQ[0];

  // ****************************************
  // spindle slices
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : gSpindle
    wire logic active = (i == 0) || dualMode;
    wire logic selected = dualMode ? link.spindleSelect[i] : 1'b1;
    wire asc_pkg::asc_gear_t extGear = (i == 0) ? link.gearCodeFirst
                                                : link.gearCodeSecond;
    wire asc_pkg::asc_gear_t nextGear = (autoMode && i == 0) ? autoGear : extGear;
    // zero command clears every spindle; other stops leave it
    wire logic zeroCmd = cmdWrite && writedata[SPD_W-1:0] == '0;
    wire logic takeCmd = cmdWrite && active && selected;
    wire asc_pkg::asc_code_t extIn = (i == 0) ? link.extCodeFirst
                                              : link.extCodeSecond;
    wire logic useExt = link.speedSourceSelect[i];
    wire logic zeroOut = spdQ[i] == '0 && !useExt;
    // the PLC sees the selected code, the converter its compensated form
    wire asc_pkg::asc_code_t cmdCode = useExt ? extIn : rawCode[i];

    asc_scale #(.SPD_W(SPD_W)) uScale (
      .speed(spdQ[i]),
      .maxSpeed(maxQ[i][gearQ[i]]),
      .extCode(extIn),
      .useExt(useExt),
      .gain(gainQ),
      .offset(offsetQ),
      .rawCode(rawCode[i]),
      .finalCode(finalCode[i])
    );

    always_ff @(posedge mclk) begin
      if (rst) begin
        spdQ[i] <= '0;
        gearQ[i] <= 2'd0;
      end else begin
        if (zeroCmd) spdQ[i] <= '0;
        else if (takeCmd) spdQ[i] <= writedata[SPD_W-1:0];
        if (!tapping) gearQ[i] <= nextGear;
      end
    end

    // PLC code registered every cycle; converter code zeroed on stop, held while not enabled
    always_ff @(posedge mclk) begin
      if (rst) begin
        codeOutQ[i] <= 12'h000;
        convQ[i] <= 12'h000;
      end else begin
        codeOutQ[i] <= zeroOut ? 12'h000 : cmdCode;
        if (!link.stopN[i]) convQ[i] <= 12'h000;
        else if (link.spindleEnable[i]) convQ[i] <= zeroOut ? 12'h000 : finalCode[i];
      end
    end
  end

  // ****************************************
  // machine-logic outputs
  // ****************************************
  // strobe only when the auto scheme changes gear
  wire logic gearMoves = autoMode && !tapping && autoGear != gearQ[0];
  always_ff @(posedge mclk) begin
    if (rst) strobeQ <= 1'b0;
    else strobeQ <= gearMoves;
  end

  assign link.gearIndication = gearOneHot;
  assign link.speedStrobe = strobeQ;
  assign link.computedCodeFirst = codeOutQ[0];
  assign link.computedCodeSecond = codeOutQ[1];
  assign converterCodeFirst = convQ[0];
  assign converterCodeSecond = convQ[1];
endmodule // asc_dev
`default_nettype wire

// [verilog/asc_params.svh]
/*
  Constants for the analog spindle speed block: register word indices,
  control bit positions and scaling figures.
  Assumes inclusion by bare name from design files.
*/
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH
// ****************************************
// register word indices (Avalon word address)
// ****************************************
`define ASC_REG_CTRL 4'h0
`define ASC_REG_SPEED 4'h1
`define ASC_REG_GAIN 4'h2
`define ASC_REG_OFFSET 4'h3
`define ASC_REG_MAX1 4'h4
`define ASC_REG_MAX2 4'h8
`define ASC_REG_CODES 4'hC
`define ASC_REG_GEARS 4'hD
// ****************************************
// control bits and reset value
// ****************************************
`define ASC_CTRL_SCHEME 0
`define ASC_CTRL_DUAL 1
`define ASC_CTRL_TAP 2
`define ASC_CTRL_W 3
`define ASC_CTRL_RST 3'h0
// ****************************************
// scaling
// ****************************************
`define ASC_FULL_CODE 12'hFFF
`define ASC_COMP_BASE 32'sd9999
`define ASC_FULL_INT 32'sd4095
`define ASC_GEARS 4
`endif

// [verilog/asc_pkg.sv]
/*
  Types shared by both ends of the analog spindle speed block.
  Assumes nothing of its surroundings.
*/
package asc_pkg;
  typedef logic [11:0] asc_code_t;
  typedef logic [15:0] asc_speed_t;
  typedef logic [1:0] asc_gear_t;
  typedef enum logic {
    ASC_EXT_GEAR = 1'b0,
    ASC_AUTO_GEAR = 1'b1
  } asc_scheme_t;
endpackage

// [verilog/asc_if.sv]
/*
  Machine-logic link between the spindle speed device and the machine PLC.
  Assumes both ends run on the same mclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface asc_if;
  logic [1:0] spindleSelect;
  logic [1:0] gearCodeFirst;
  logic [1:0] gearCodeSecond;
  logic [1:0] speedSourceSelect;
  asc_pkg::asc_code_t extCodeFirst;
  asc_pkg::asc_code_t extCodeSecond;
  logic [1:0] stopN;
  logic [1:0] spindleEnable;
  logic [3:0] gearIndication;
  logic speedStrobe;
  asc_pkg::asc_code_t computedCodeFirst;
  asc_pkg::asc_code_t computedCodeSecond;
  modport dev (
    input spindleSelect, gearCodeFirst, gearCodeSecond, speedSourceSelect,
    input extCodeFirst, extCodeSecond, stopN, spindleEnable,
    output gearIndication, speedStrobe, computedCodeFirst, computedCodeSecond
  );
  modport plc (
    output spindleSelect, gearCodeFirst, gearCodeSecond, speedSourceSelect,
    output extCodeFirst, extCodeSecond, stopN, spindleEnable,
    input gearIndication, speedStrobe, computedCodeFirst, computedCodeSecond
  );
endinterface
`default_nettype wire

// [verilog/asc_scale.sv]
/*
  Combinational speed scaling: speed to 12-bit code by gear maximum,
  source selection, then gain and zero-offset compensation with clamping.
  Assumes registered inputs from the instantiating spindle slice.
*/
`timescale 1ns/100ps
`default_nettype none
`include "asc_params.svh"
module asc_scale #(
  parameter int SPD_W = 16
) (
  input wire logic [SPD_W-1:0] speed,
  input wire logic [SPD_W-1:0] maxSpeed,
  input wire asc_pkg::asc_code_t extCode,
  input wire logic useExt,
  input wire logic signed [15:0] gain,
  input wire logic signed [15:0] offset,
  output asc_pkg::asc_code_t rawCode,
  output asc_pkg::asc_code_t finalCode
);
  if (SPD_W < 2 || SPD_W > 16) $error("asc_scale: SPD_W out of range");
  // ****************************************
  // speed to code
  // ****************************************
  wire logic [31:0] prod = 32'({16'h0000, 16'(speed)} * 32'h0000_0FFF);
  wire logic [31:0] quot = (maxSpeed == '0) ? 32'h0 : prod / 32'(maxSpeed);
  // linear in speed, clamped when above gear maximum
  assign rawCode = (quot > 32'h0000_0FFF) ? `ASC_FULL_CODE : quot[11:0];
  wire asc_pkg::asc_code_t selCode = useExt ? extCode : rawCode;
  // ****************************************
  // compensation
  // ****************************************
  wire logic signed [31:0] factor = `ASC_COMP_BASE + 32'(gain) - 32'(offset);
  wire logic signed [31:0] scaled = ($signed({20'h0, selCode}) * factor)
                                    / `ASC_COMP_BASE;
  wire logic signed [31:0] shift = (32'(offset) * `ASC_FULL_INT) / `ASC_COMP_BASE;
  wire logic signed [31:0] total = scaled + shift;
  // clamp instead of wrap
  assign finalCode = (total < 0) ? 12'h000 :
                     (total > `ASC_FULL_INT) ? `ASC_FULL_CODE : total[11:0];
endmodule // asc_scale
`default_nettype wire

// [verilog/asc_plc.sv]
/*
  Machine-logic (PLC) end: registers its user-side orders onto the link and
  reports the device's indications and codes back.
  Assumes the same mclk as the device end.
*/
`timescale 1ns/100ps
`default_nettype none
module asc_plc (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] selectIn,
  input wire logic [1:0] gearFirstIn,
  input wire logic [1:0] gearSecondIn,
  input wire logic [1:0] sourceIn,
  input wire asc_pkg::asc_code_t extFirstIn,
  input wire asc_pkg::asc_code_t extSecondIn,
  input wire logic [1:0] stopInN,
  input wire logic [1:0] enableIn,
  output logic [3:0] gearIndicationOut,
  output logic speedStrobeOut,
  output asc_pkg::asc_code_t codeFirstOut,
  output asc_pkg::asc_code_t codeSecondOut,
  asc_if.plc link
);
  // ****************************************
  // orders toward the device
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.spindleSelect <= 2'h0;
      link.gearCodeFirst <= 2'h0;
      link.gearCodeSecond <= 2'h0;
      link.speedSourceSelect <= 2'h0;
      link.extCodeFirst <= 12'h000;
      link.extCodeSecond <= 12'h000;
      link.stopN <= 2'h3;
      link.spindleEnable <= 2'h3;
    end else begin
      link.spindleSelect <= selectIn;
      link.gearCodeFirst <= gearFirstIn;
      link.gearCodeSecond <= gearSecondIn;
      link.speedSourceSelect <= sourceIn;
      link.extCodeFirst <= extFirstIn;
      link.extCodeSecond <= extSecondIn;
      link.stopN <= stopInN;
      link.spindleEnable <= enableIn;
    end
  end
  // ****************************************
  // reports from the device
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      gearIndicationOut <= 4'h0;
      speedStrobeOut <= 1'b0;
      codeFirstOut <= 12'h000;
      codeSecondOut <= 12'h000;
    end else begin
      gearIndicationOut <= link.gearIndication;
      speedStrobeOut <= link.speedStrobe;
      codeFirstOut <= link.computedCodeFirst;
      codeSecondOut <= link.computedCodeSecond;
    end
  end
endmodule // asc_plc
`default_nettype wire

// [dv/asc_checker.sv]
/*
  Link checker for the spindle speed block: timing and value relations.
  Assumes all link signals on mclk with synchronous reset rst.
*/
`timescale 1ns/100ps
`default_nettype none
module asc_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] spindleSelect,
  input wire logic [1:0] gearCodeFirst,
  input wire logic [1:0] gearCodeSecond,
  input wire logic [1:0] speedSourceSelect,
  input wire asc_pkg::asc_code_t extCodeFirst,
  input wire asc_pkg::asc_code_t extCodeSecond,
  input wire logic [1:0] stopN,
  input wire logic [1:0] spindleEnable,
  input wire logic [3:0] gearIndication,
  input wire logic speedStrobe,
  input wire asc_pkg::asc_code_t computedCodeFirst,
  input wire asc_pkg::asc_code_t computedCodeSecond
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // cycles since the source select last moved
  logic [2:0] srcAgeQ;
  always_ff @(posedge mclk) begin
    if (rst || $changed(speedSourceSelect)) begin
      srcAgeQ <= 3'h0;
    end else if (srcAgeQ != 3'h7) begin
      srcAgeQ <= srcAgeQ + 3'h1;
    end
  end
  gear_onehot_a: assert property ($onehot(gearIndication))
    else $error("gear indication not one-hot");
  reset_clear_a: assert property ($fell(rst) |-> computedCodeFirst == 12'h000
    && computedCodeSecond == 12'h000 && gearIndication == 4'h1 && !speedStrobe)
    else $error("outputs not cleared by reset");
  strobe_pulse_a: assert property (speedStrobe |=> !speedStrobe)
    else $error("strobe longer than one cycle");
  ext_follow_a: assert property ((speedSourceSelect[0] && $stable(speedSourceSelect)
    && srcAgeQ != 3'h0) |=> computedCodeFirst == $past(extCodeFirst))
    else $error("first code does not follow external code");
  src_switch_a: assert property (($rose(speedSourceSelect[0]) ##1
    (speedSourceSelect[0] && $stable(extCodeFirst)) [*2]) |-> computedCodeFirst == extCodeFirst)
    else $error("source switch late");
  ext_second_a: assert property ((speedSourceSelect[1] && $stable(speedSourceSelect)
    && srcAgeQ != 3'h0) |=> computedCodeSecond == $past(extCodeSecond))
    else $error("second code does not follow its external code");
  first_isolated_a: assert property (($changed(extCodeFirst) && speedSourceSelect[1]
    && $stable(speedSourceSelect) && $stable(extCodeSecond)) |=> $stable(computedCodeSecond))
    else $error("first external code reached second spindle");
  gear_ignored_a: assert property (($changed(gearCodeSecond) && speedSourceSelect[1]
    && $stable(speedSourceSelect) && $stable(extCodeSecond)) |=> $stable(computedCodeSecond))
    else $error("gear moved an external code");
  stop_keeps_a: assert property ($changed(stopN) |=> $stable(computedCodeFirst) [*3])
    else $error("stop changed the speed command");
  cover property (speedStrobe);
  cover property (speedSourceSelect == 2'h2 && $changed(extCodeFirst));
  cover property (gearIndication == 4'h8);
endmodule // asc_checker
`default_nettype wire

// [dv/asc_tb.sv]
/*
  Bench: both ends joined over the link, registers over Avalon-MM.
  Assumes the design files and header from verilog/.
*/
`timescale 1ns/100ps
`default_nettype none
`include "asc_params.svh"
module asc_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rdv;
  logic waitrequest, strobeOut;
  logic [1:0] selectIn = 2'h0, gearFirstIn = 2'h0, gearSecondIn = 2'h0;
  logic [1:0] sourceIn = 2'h0, stopInN = 2'h3, enableIn = 2'h3;
  logic [3:0] gearIndOut;
  asc_pkg::asc_code_t extFirstIn = 12'h000, extSecondIn = 12'h000;
  asc_pkg::asc_code_t convFirst, convSecond, codeFirstOut, codeSecondOut;
  int failCount = 0, nChecks = 0, cycles = 0, strobes = 0;
  int mx1[4] = '{1000, 2000, 4000, 5000};
  int mx2[4] = '{500, 1000, 2000, 4000};
  int cg[4] = '{1111, 1111, 9999, -1111};
  int co[4] = '{0, 1111, 0, -1111};
  int cs[4] = '{909, 909, 4095, 100};
  int ce[4] = '{1010, 1364, 4095, 0};
  int asp[3] = '{1500, 4500, 800};
  int ag[3] = '{1, 3, 0};
  int ra[6] = '{0, 2, 4, 12, 13, 14};
  asc_if link ();
  asc_dev i_asc_dev (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .link(link),
    .converterCodeFirst(convFirst), .converterCodeSecond(convSecond));
  asc_plc i_asc_plc (.mclk(mclk), .rst(rst), .selectIn(selectIn), .gearFirstIn(gearFirstIn),
    .gearSecondIn(gearSecondIn), .sourceIn(sourceIn), .extFirstIn(extFirstIn),
    .extSecondIn(extSecondIn), .stopInN(stopInN), .enableIn(enableIn),
    .gearIndicationOut(gearIndOut), .speedStrobeOut(strobeOut), .codeFirstOut(codeFirstOut),
    .codeSecondOut(codeSecondOut), .link(link));
  asc_checker i_asc_checker (.mclk(mclk), .rst(rst), .spindleSelect(link.spindleSelect),
    .gearCodeFirst(link.gearCodeFirst), .gearCodeSecond(link.gearCodeSecond),
    .speedSourceSelect(link.speedSourceSelect), .extCodeFirst(link.extCodeFirst),
    .extCodeSecond(link.extCodeSecond), .stopN(link.stopN), .spindleEnable(link.spindleEnable),
    .gearIndication(link.gearIndication), .speedStrobe(link.speedStrobe),
    .computedCodeFirst(link.computedCodeFirst), .computedCodeSecond(link.computedCodeSecond));
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (strobeOut === 1'b1) strobes <= strobes + 1;
    if (cycles == 3000) begin
      failCount++;
      results();
    end
  end
  // ****
  // tasks
  // ****
  task automatic results();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic rw, input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= ~rw;
    write <= rw;
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input int d);
    bus(1'b1, a, 32'(d));
  endtask
  task automatic rd(input logic [3:0] a, input int e);
    bus(1'b0, a, 32'h0);
    chk(rdv, 32'(e));
  endtask
  task automatic settle();
    repeat (6) @(posedge mclk);
  endtask
  task automatic spd(input int s);
    wr(`ASC_REG_SPEED, s);
    settle();
  endtask
  task automatic codes(input int sp, input int c, input int v);
    chk({20'h0, (sp != 0) ? codeSecondOut : codeFirstOut}, 32'(c));
    chk({20'h0, (sp != 0) ? convSecond : convFirst}, 32'(v));
  endtask
  function automatic int scale(input int s, input int m);
    return (s * 4095 / m > 4095) ? 4095 : s * 4095 / m;
  endfunction
  // ****
  // sequence
  // ****
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    foreach (ra[i]) rd(4'(ra[i]), 0);
    for (int i = 0; i < 4; i++) wr(`ASC_REG_MAX1 + 4'(i), mx1[i]);
    selectIn <= 2'h3;
    spd(800);
    for (int i = 0; i < 4; i++) begin
      gearFirstIn <= 2'(i);
      settle();
      codes(0, scale(800, mx1[i]), scale(800, mx1[i]));
      chk(32'(gearIndOut), 32'(1 << i));
      rd(`ASC_REG_GEARS, i);
    end
    rd(`ASC_REG_CODES, scale(800, 5000));
    spd(6000);
    codes(0, 4095, 4095);
    chk(32'(strobes), 0);
    gearFirstIn <= 2'h0;
    wr(`ASC_REG_MAX1, 4095);
    for (int i = 0; i < 4; i++) begin
      wr(`ASC_REG_GAIN, cg[i] & 16'hFFFF);
      wr(`ASC_REG_OFFSET, co[i] & 16'hFFFF);
      spd(cs[i]);
      codes(0, cs[i], ce[i]);
    end
    wr(`ASC_REG_GAIN, 0);
    wr(`ASC_REG_OFFSET, 0);
    stopInN <= 2'h2;
    settle();
    codes(0, 100, 0);
    stopInN <= 2'h3;
    settle();
    codes(0, 100, 100);
    enableIn <= 2'h2;
    spd(200);
    codes(0, 200, 100);
    enableIn <= 2'h3;
    spd(0);
    codes(0, 0, 0);
    sourceIn <= 2'h1;
    extFirstIn <= 12'hABC;
    settle();
    codes(0, 'hABC, 'hABC);
    sourceIn <= 2'h0;
    wr(`ASC_REG_CTRL, 2);
    for (int i = 0; i < 4; i++) wr(`ASC_REG_MAX2 + 4'(i), mx2[i]);
    selectIn <= 2'h1;
    spd(800);
    codes(1, 0, 0);
    selectIn <= 2'h2;
    for (int i = 0; i < 4; i++) begin
      gearSecondIn <= 2'(i);
      spd(400);
      codes(1, scale(400, mx2[i]), scale(400, mx2[i]));
      codes(0, 800, 800);
    end
    stopInN <= 2'h1;
    settle();
    codes(1, scale(400, mx2[3]), 0);
    codes(0, 800, 800);
    stopInN <= 2'h3;
    sourceIn <= 2'h2;
    extSecondIn <= 12'h123;
    extFirstIn <= 12'h456;
    settle();
    gearSecondIn <= 2'h1;
    extFirstIn <= 12'h654;
    settle();
    codes(1, 'h123, 'h123);
    codes(0, 800, 800);
    rd(`ASC_REG_CODES, 'h123320);
    sourceIn <= 2'h0;
    wr(`ASC_REG_CTRL, 3);
    selectIn <= 2'h3;
    spd(2000);
    codes(1, 1638, 1638);
    wr(`ASC_REG_CTRL, 1);
    wr(`ASC_REG_MAX1, 1000);
    wr(`ASC_REG_MAX1 + 4'h2, 0);
    spd(3000);
    chk(32'(gearIndOut), 32'h8);
    codes(0, scale(3000, mx1[3]), scale(3000, mx1[3]));
    for (int i = 0; i < 3; i++) begin
      spd(asp[i]);
      chk(32'(gearIndOut), 32'(1 << ag[i]));
      codes(0, scale(asp[i], mx1[ag[i]]), scale(asp[i], mx1[ag[i]]));
    end
    chk(32'(strobes != 0), 1);
    wr(`ASC_REG_CTRL, 5);
    spd(1500);
    chk(32'(gearIndOut), 1);
    codes(0, 4095, 4095);
    results();
  end
endmodule // asc_tb
`default_nettype wire
